// ---- src/sadc_cfg.svh ----
/*
  Constants of the converter sequencer: register indices, field positions,
  reset values, pin masks and sequence lengths counted in half bit periods.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

// Register indices; byte address is four times the index
`define SADC_IDX_CTRL      12'h01F
`define SADC_IDX_PCFG      12'h09F
`define SADC_IDX_RESULT    12'h020
`define SADC_IDX_STATUS    12'h021
`define SADC_IDX_PORT      12'h022

// Control register fields
`define SADC_CS_HI         7
`define SADC_CS_LO         6
`define SADC_CH_HI         5
`define SADC_CH_LO         3
`define SADC_GO_BIT        2
`define SADC_ON_BIT        0

// Status register field
`define SADC_FLAG_BIT      0

// Reset values
`define SADC_RST_BYTE      8'h00
`define SADC_RST_CS        2'h0
`define SADC_RST_CH        3'h0
`define SADC_RST_PCFG      3'h0
`define SADC_RST_DIV       5'h00

// Half bit-period reloads for the oscillator dividers (count minus one)
`define SADC_HDIV_OSC2     5'h00
`define SADC_HDIV_OSC8     5'h03
`define SADC_HDIV_OSC32    5'h0F

// Sequence lengths in half bit periods: 3 + 2*8 = 19 (9.5 periods)
`define SADC_HALF_SAMPLE   5'h03
`define SADC_HALF_RECOVER  5'h04

// Analog pin masks, channel order 0..7
`define SADC_MASK_ALL      8'hFF
`define SADC_MASK_NO_E     8'h1F
`define SADC_MASK_013      8'h0B
`define SADC_MASK_NONE     8'h00

// Pin configuration codes
`define SADC_PCFG_NO_E     2'h1
`define SADC_PCFG_013      2'h2
`define SADC_PCFG_DIGITAL  2'h3

`endif

// ---- src/sadc_pkg.sv ----
/*
  Types of the converter sequencer: sequence states and clock choices.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sadc_pkg;

  // Conversion sequence states
  typedef enum logic [1:0] {
    SADC_ST_ACQUIRE,
    SADC_ST_SAMPLE,
    SADC_ST_CONVERT,
    SADC_ST_RECOVER
  } sadc_state_e;

  // Conversion clock choices
  typedef enum logic [1:0] {
    SADC_CLK_OSC2  = 2'h0,
    SADC_CLK_OSC8  = 2'h1,
    SADC_CLK_OSC32 = 2'h2,
    SADC_CLK_RC    = 2'h3
  } sadc_clk_e;

  typedef logic [7:0] sadc_byte_t;

endpackage

// ---- src/sadc_sar_core.sv ----
/*
  Successive-approximation register: trial code for the DAC, one bit
  decided per step from the comparator.
  Assumes load and step come from the sequencer, comparator synchronous.
*/
`timescale 1ns/1ps
module sadc_sar_core #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Sequencer control
  input  wire logic             load,
  input  wire logic             step,
  input  wire logic             cmp_above,
  // Codes
  output logic [WIDTH-1:0]      trial_ff,
  output logic [WIDTH-1:0]      nxt_result
);
  logic [WIDTH-1:0] mask_ff;
  logic [WIDTH-1:0] nxt_trial;
  logic [WIDTH-1:0] nxt_mask;
  logic [WIDTH-1:0] msb_only;

  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("sadc_sar_core: WIDTH must be 1 to 8");
  end

  assign msb_only = {1'b1, {(WIDTH-1){1'b0}}};

  // Keep the bit under trial if input is above, then try the next one
  assign nxt_result = cmp_above ? trial_ff : (trial_ff & ~mask_ff);
  assign nxt_mask   = load ? msb_only : (step ? (mask_ff >> 1) : mask_ff);
  assign nxt_trial  = load ? msb_only : (step ? (nxt_result | (mask_ff >> 1)) : trial_ff);

  // Trial and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial_ff <= '0;
      mask_ff  <= '0;
    end else begin
      trial_ff <= nxt_trial;
      mask_ff  <= nxt_mask;
    end
  end

endmodule

// ---- src/sadc_top.sv ----
/*
  Sequencer of an 8-bit successive-approximation converter behind an APB
  slave: clock choice, channel and pin configuration, start, abort, result,
  done flag and recovery wait.
  Assumes a comparator and analog mux outside, inputs synchronous to pclk,
  and an internal RC oscillator level arriving asynchronously.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_top #(
  parameter int NUM_CH = 8,
  parameter int WIDTH  = 8
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic [13:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata_ff,
  output logic                       pready_ff,
  output logic                       pslverr_ff,
  // Device state
  input  wire logic                  sleep_mode,
  input  wire logic                  internal_rc_clock,
  input  wire logic [7:0]            port_pin_levels,
  // Analog front end
  input  wire logic                  cmp_above,
  output logic [WIDTH-1:0]           dac_code_ff,
  output logic                       sample_switch_ff,
  output logic [2:0]                 channel_select_ff,
  output logic                       vref_from_pin_ff,
  output logic [7:0]                 analog_mask_ff,
  output logic                       conv_power_on_ff,
  // Status towards the interrupt controller
  output logic                       conv_done_flag_ff,
  output sadc_pkg::sadc_byte_t       conv_result_reg_ff
);
  import sadc_pkg::*;

  // Last half tick of the conversion phase
  localparam logic [4:0] CONV_LAST = 5'(2 * WIDTH - 1);

  // Refuse parameter values the sequencer cannot serve
  if (NUM_CH != 5 && NUM_CH != 8) begin
    $error("sadc_top: NUM_CH must be 5 or 8");
  end
  if (WIDTH < 1 || WIDTH > 8) begin
    $error("sadc_top: WIDTH must be 1 to 8");
  end

  // Sequencer state and half-tick counter
  sadc_state_e      state_ff;
  sadc_state_e      nxt_state;
  logic [4:0]       cnt_ff;
  logic [4:0]       nxt_cnt;

  // Oscillator divider
  logic [4:0]       div_ff;
  logic [4:0]       nxt_div;

  // Software fields and next values
  logic [1:0]       conv_clock_select_ff;
  logic [2:0]       pin_config_select_ff;
  logic             go_ff;
  logic             nxt_go;
  logic             nxt_on;
  logic             nxt_flag;
  logic [7:0]       nxt_result;

  // RC synchroniser and edge finder
  logic             rc_meta_ff;
  logic             rc_sync_ff;
  logic             rc_last_ff;

  // Approximation core handshake
  logic             core_load;
  logic             core_step;
  logic             conv_done;
  logic [WIDTH-1:0] core_result;

  // APB decode
  wire        acc_phase  = psel & penable & ~pready_ff;
  wire        commit     = psel & penable & pready_ff;
  wire [11:0] reg_idx    = paddr[13:2];
  wire        aligned    = (paddr[1:0] == 2'h0);

  // Register hits, unaligned addresses miss
  wire        hit_ctrl   = aligned & (reg_idx == `SADC_IDX_CTRL);
  wire        hit_pcfg   = aligned & (reg_idx == `SADC_IDX_PCFG);
  wire        hit_result = aligned & (reg_idx == `SADC_IDX_RESULT);
  wire        hit_status = aligned & (reg_idx == `SADC_IDX_STATUS);
  wire        hit_port   = aligned & (reg_idx == `SADC_IDX_PORT);
  wire        addr_ok    = hit_ctrl | hit_pcfg | hit_result | hit_status | hit_port;

  // Write strobes, only at the completing edge
  wire        wr_ctrl    = commit & pwrite & hit_ctrl;
  wire        wr_pcfg    = commit & pwrite & hit_pcfg;
  wire        wr_result  = commit & pwrite & hit_result;
  wire        wr_status  = commit & pwrite & hit_status;

  // Software start and abort
  // Start needs power already on; start bit low while busy aborts
  wire start_wr  = wr_ctrl & pwdata[`SADC_GO_BIT] & conv_power_on_ff;
  wire busy      = (state_ff == SADC_ST_SAMPLE) | (state_ff == SADC_ST_CONVERT);
  wire abort_wr  = wr_ctrl & ~pwdata[`SADC_GO_BIT] & busy;
  wire flag_clr  = wr_status & pwdata[`SADC_FLAG_BIT];

  // Power and status bit next values
  assign nxt_on = wr_ctrl ? pwdata[`SADC_ON_BIT] : conv_power_on_ff;
  assign nxt_go = ~nxt_on ? 1'b0 :
                  wr_ctrl ? start_wr :
                  conv_done ? 1'b0 : go_ff;

  // Set wins over a clear in the same cycle
  assign nxt_flag   = conv_done | (conv_done_flag_ff & ~flag_clr);
  assign nxt_result = conv_done ? 8'(core_result) :
                      wr_result ? pwdata[7:0] : conv_result_reg_ff;

  // Half bit-period tick from the chosen clock
  // Each RC edge is one half period; oscillators use the divider
  wire rc_sel    = (conv_clock_select_ff == SADC_CLK_RC);
  wire rc_edge   = rc_sync_ff ^ rc_last_ff;
  wire [4:0] div_reload =
      (conv_clock_select_ff == SADC_CLK_OSC2)  ? `SADC_HDIV_OSC2 :
      (conv_clock_select_ff == SADC_CLK_OSC8)  ? `SADC_HDIV_OSC8 :
                                                 `SADC_HDIV_OSC32;
  wire osc_run   = ~rc_sel & ~sleep_mode;
  wire osc_tick  = osc_run & (div_ff == 5'h00);
  wire half_tick = rc_sel ? rc_edge : osc_tick;
  assign nxt_div = ~osc_run ? `SADC_RST_DIV :
                   (div_ff == 5'h00) ? div_reload : (div_ff - 5'h01);

  // Analog pins per configuration code
  wire [7:0] exist_mask = (NUM_CH == 8) ? `SADC_MASK_ALL : `SADC_MASK_NO_E;
  wire [7:0] cfg_mask =
      (pin_config_select_ff[2:1] == `SADC_PCFG_DIGITAL) ? `SADC_MASK_NONE :
      (pin_config_select_ff[2:1] == `SADC_PCFG_013)     ? `SADC_MASK_013 :
      (pin_config_select_ff[2:1] == `SADC_PCFG_NO_E)    ? `SADC_MASK_NO_E :
                                                          `SADC_MASK_ALL;
  wire [7:0] nxt_mask = cfg_mask & exist_mask;
  wire nxt_vref_pin = pin_config_select_ff[0] &
                      (pin_config_select_ff[2:1] != `SADC_PCFG_DIGITAL);

  // Read data selection
  wire [7:0] rd_ctrl   = {conv_clock_select_ff, channel_select_ff, go_ff,
                          1'b0, conv_power_on_ff};
  wire [7:0] rd_pcfg   = {5'h00, pin_config_select_ff};
  wire [7:0] rd_status = {7'h00, conv_done_flag_ff};
  wire [7:0] rd_port   = port_pin_levels & ~analog_mask_ff;
  wire [7:0] rd_byte   = hit_ctrl   ? rd_ctrl :
                         hit_pcfg   ? rd_pcfg :
                         hit_result ? conv_result_reg_ff :
                         hit_status ? rd_status :
                         hit_port   ? rd_port : `SADC_RST_BYTE;

  // Conversion sequence
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    core_load = 1'b0;
    core_step = 1'b0;
    conv_done = 1'b0;
    if (!conv_power_on_ff) begin
      nxt_state = SADC_ST_ACQUIRE;
      nxt_cnt   = 5'h00;
    end else begin
      unique case (state_ff)
        SADC_ST_ACQUIRE: begin
          // Leave acquisition once a start is pending
          if (go_ff) begin
            nxt_state = SADC_ST_SAMPLE;
            nxt_cnt   = 5'h00;
          end
        end
        SADC_ST_SAMPLE: begin
          // Hold the sample for three half ticks
          if (abort_wr) begin
            nxt_state = SADC_ST_RECOVER;
            nxt_cnt   = 5'h00;
          end else if (half_tick) begin
            if (cnt_ff == `SADC_HALF_SAMPLE - 5'h01) begin
              nxt_state = SADC_ST_CONVERT;
              nxt_cnt   = 5'h00;
              core_load = 1'b1;
            end else begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
        end
        SADC_ST_CONVERT: begin
          // One bit decided every second half tick
          if (abort_wr) begin
            nxt_state = SADC_ST_RECOVER;
            nxt_cnt   = 5'h00;
          end else if (half_tick) begin
            core_step = cnt_ff[0];
            if (cnt_ff == CONV_LAST) begin
              conv_done = 1'b1;
              nxt_state = SADC_ST_RECOVER;
              nxt_cnt   = 5'h00;
            end else begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
        end
        SADC_ST_RECOVER: begin
          // Switch stays open for two bit periods
          if (half_tick) begin
            if (cnt_ff == `SADC_HALF_RECOVER - 5'h01) begin
              nxt_state = SADC_ST_ACQUIRE;
              nxt_cnt   = 5'h00;
            end else begin
              nxt_cnt = cnt_ff + 5'h01;
            end
          end
        end
      endcase
    end
  end

  // Approximation register
  sadc_sar_core #(
    .WIDTH      (WIDTH)
  ) u_core (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (core_load),
    .step       (core_step),
    .cmp_above  (cmp_above),
    .trial_ff   (dac_code_ff),
    .nxt_result (core_result)
  );

  // RC oscillator synchroniser
  // Two flops against metastability, a third to find edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_last_ff <= 1'b0;
    end else begin
      rc_meta_ff <= internal_rc_clock;
      rc_sync_ff <= rc_meta_ff;
      rc_last_ff <= rc_sync_ff;
    end
  end

  // Sequencer state and divider
  // Divider restarts whenever the oscillator clocks stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SADC_ST_ACQUIRE;
      cnt_ff   <= 5'h00;
      div_ff   <= `SADC_RST_DIV;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      div_ff   <= nxt_div;
    end
  end

  // Software registers
  // Pin config bits 7-3 are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clock_select_ff <= `SADC_RST_CS;
      channel_select_ff    <= `SADC_RST_CH;
      go_ff                <= 1'b0;
      conv_power_on_ff     <= 1'b0;
      pin_config_select_ff <= `SADC_RST_PCFG;
      conv_done_flag_ff    <= 1'b0;
      conv_result_reg_ff   <= `SADC_RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        conv_clock_select_ff <= pwdata[`SADC_CS_HI:`SADC_CS_LO];
        channel_select_ff    <= pwdata[`SADC_CH_HI:`SADC_CH_LO];
      end
      if (wr_pcfg) begin
        pin_config_select_ff <= pwdata[2:0];
      end
      go_ff              <= nxt_go;
      conv_power_on_ff   <= nxt_on;
      conv_done_flag_ff  <= nxt_flag;
      conv_result_reg_ff <= nxt_result;
    end
  end

  // Pin and switch outputs
  // Switch closes only while acquiring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_switch_ff <= 1'b0;
      vref_from_pin_ff <= 1'b0;
      analog_mask_ff   <= `SADC_MASK_NONE;
    end else begin
      sample_switch_ff <= conv_power_on_ff & (nxt_state == SADC_ST_ACQUIRE);
      vref_from_pin_ff <= nxt_vref_pin;
      analog_mask_ff   <= nxt_mask;
    end
  end

  // APB answer: one wait state, data and error with ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc_phase;
      pslverr_ff <= acc_phase & ~addr_ok;
      if (acc_phase & ~pwrite) begin
        prdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule

// ---- testbench/sadc_afe_model.sv ----
/* Analog front end: channel levels, sample-and-hold and comparator.
   Assumes the sequencer closes the switch to acquire and steps the DAC. */
`timescale 1ns/1ps
module sadc_afe_model (
  // Clock
  input wire logic        pclk,
  // Sequencer side
  input wire logic [7:0]  dac_code,
  input wire logic        sample_switch,
  input wire logic        power_on,
  input wire logic [2:0]  channel,
  // Source levels, one byte per channel
  input wire logic [63:0] chan_levels,
  output logic            cmp_above
);
  logic [7:0] held_ff;
  logic       noise_ff = 1'h0;
  // Hold capacitor tracks the channel while the switch is closed
  always_ff @(posedge pclk) begin
    if (sample_switch) held_ff <= chan_levels[channel*8 +: 8];
    noise_ff <= ~noise_ff;
  end
  // Level sits half a step above its code; unpowered output wanders
  assign cmp_above = power_on ? ({held_ff, 1'h1} > {dac_code, 1'h0}) : noise_ff;
endmodule

// ---- testbench/sadc_top_monitor.sv ----
/* Port checker of the sequencer: APB answer, pin table, routing, result,
   recovery and conversion length. Assumes a bind onto sadc_top. */
`timescale 1ns/1ps
`include "sadc_cfg.svh"
module sadc_top_monitor #(
  parameter int NUM_CH = 8,
  parameter int WIDTH  = 8
) (
  // Clock, reset and APB
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic [13:0]          paddr,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata_ff,
  input wire logic                 pready_ff,
  input wire logic                 pslverr_ff,
  // Device state and front end
  input wire logic                 sleep_mode,
  input wire logic [WIDTH-1:0]     dac_code_ff,
  input wire logic                 sample_switch_ff,
  input wire logic [2:0]           channel_select_ff,
  input wire logic                 vref_from_pin_ff,
  input wire logic [7:0]           analog_mask_ff,
  input wire logic                 conv_power_on_ff,
  input wire logic                 conv_done_flag_ff,
  input wire sadc_pkg::sadc_byte_t conv_result_reg_ff
);
  import sadc_pkg::*;
  localparam logic [13:0] A_CTRL = {`SADC_IDX_CTRL, 2'h0};
  localparam logic [13:0] A_PCFG = {`SADC_IDX_PCFG, 2'h0};
  localparam logic [13:0] A_RES  = {`SADC_IDX_RESULT, 2'h0};
  localparam logic [13:0] A_PORT = {`SADC_IDX_PORT, 2'h0};
  logic       commit;
  logic [3:0] ctrl_hist_ff;
  logic [1:0] cs_ff;
  logic [2:0] pcfg_ff;
  logic [7:0] exp_mask;
  // Write commit and expected analog pin mask
  assign commit   = psel & penable & pready_ff & pwrite;
  assign exp_mask = (pcfg_ff[2:1] == 2'h0 ? `SADC_MASK_ALL : pcfg_ff[2:1] == 2'h1 ?
                    `SADC_MASK_NO_E : pcfg_ff[2:1] == 2'h2 ? `SADC_MASK_013 :
                    `SADC_MASK_NONE) & (NUM_CH == 5 ? 8'h1F : 8'hFF);
  // Shadows of clock choice, pin code and recent control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_hist_ff <= 4'h0;
      cs_ff        <= 2'h0;
      pcfg_ff      <= 3'h0;
    end else begin
      ctrl_hist_ff <= {ctrl_hist_ff[2:0], commit && paddr == A_CTRL};
      if (commit && paddr == A_CTRL) cs_ff <= pwdata[7:6];
      if (commit && paddr == A_PCFG) pcfg_ff <= pwdata[2:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ctrl_wr;
    commit && paddr == A_CTRL;
  endsequence
  sequence s_rd_ok(logic [13:0] a);
    pready_ff && !pwrite && !pslverr_ff && paddr == a;
  endsequence
  a_access_answer: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("APB answer not a single cycle after access");
  a_pcfg_upper_zero: assert property (s_rd_ok(A_PCFG) |-> prdata_ff[31:3] == 29'h0)
    else $error("pin config upper bits not zero");
  a_mask_table: assert property (commit && paddr == A_PCFG |=> ##1 analog_mask_ff == exp_mask)
    else $error("analog mask wrong for pin code");
  a_vref_choice: assert property (commit && paddr == A_PCFG |=> ##1
    vref_from_pin_ff == (pcfg_ff[0] && pcfg_ff[2:1] != 2'h3)) else $error("reference choice wrong");
  a_channel_route: assert property (s_ctrl_wr |=> channel_select_ff == $past(pwdata[5:3]))
    else $error("channel not routed");
  a_power_follow: assert property (s_ctrl_wr |=> conv_power_on_ff == $past(pwdata[0]))
    else $error("power bit not followed");
  a_result_with_flag: assert property ($changed(conv_result_reg_ff) &&
    !$past(commit && paddr == A_RES) |-> conv_done_flag_ff) else $error("result without flag");
  a_recover_gap: assert property ($rose(conv_done_flag_ff) |-> !sample_switch_ff [*4])
    else $error("acquisition resumed too early");
  a_conv_length: assert property ($fell(sample_switch_ff) && cs_ff == 2'h0 &&
    conv_power_on_ff && !conv_done_flag_ff |-> ##[16:22] $rose(conv_done_flag_ff))
    else $error("conversion length wrong");
  a_port_analog_zero: assert property (s_rd_ok(A_PORT) |->
    (prdata_ff[7:0] & analog_mask_ff) == 8'h00) else $error("analog pin read not zero");
  a_sleep_freeze: assert property (sleep_mode && $past(sleep_mode) && cs_ff != 2'h3 &&
    ctrl_hist_ff == 4'h0 |-> $stable(dac_code_ff) && $stable(conv_done_flag_ff))
    else $error("oscillator clock ran in sleep");
endmodule

// ---- testbench/sar_adc_sequencer_test.sv ----
/* Self-checking bench: APB register tasks, pin table, conversions on every
   clock choice, sleep, abort and recovery. Assumes sadc_top and the model. */
`timescale 1ns/1ps
`include "sadc_cfg.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module sar_adc_sequencer_test;
  import sadc_pkg::*;
  localparam logic [13:0] A_CTRL = {`SADC_IDX_CTRL, 2'h0};
  localparam logic [13:0] A_PCFG = {`SADC_IDX_PCFG, 2'h0};
  localparam logic [13:0] A_STAT = {`SADC_IDX_STATUS, 2'h0};
  localparam logic [13:0] A_PORT = {`SADC_IDX_PORT, 2'h0};
  localparam logic [63:0] LEVELS = 64'hC3_5A_E1_07_80_3C_96_7F;
  localparam logic [7:0]  MASKS [4] = '{`SADC_MASK_ALL, `SADC_MASK_NO_E, `SADC_MASK_013,
                                        `SADC_MASK_NONE};
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic sleep_mode = 1'h0, internal_rc_clock = 1'h0, rerr;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata_ff, rdata;
  logic [7:0]  port_pin_levels = 8'h00, dac_code_ff, analog_mask_ff;
  logic pready_ff, pslverr_ff, cmp_above, sample_switch_ff, vref_from_pin_ff;
  logic conv_power_on_ff, conv_done_flag_ff;
  logic [2:0]  channel_select_ff;
  sadc_byte_t  conv_result_reg_ff;
  int          err_count = 0, checked = 0;
  // System clock and a free-running RC oscillator of unrelated phase
  always #2.5 pclk = ~pclk;
  always #37 internal_rc_clock = ~internal_rc_clock;
  sadc_top u_sadc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff),
    .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .sleep_mode(sleep_mode),
    .internal_rc_clock(internal_rc_clock), .port_pin_levels(port_pin_levels),
    .cmp_above(cmp_above), .dac_code_ff(dac_code_ff), .sample_switch_ff(sample_switch_ff),
    .channel_select_ff(channel_select_ff), .vref_from_pin_ff(vref_from_pin_ff),
    .analog_mask_ff(analog_mask_ff), .conv_power_on_ff(conv_power_on_ff),
    .conv_done_flag_ff(conv_done_flag_ff), .conv_result_reg_ff(conv_result_reg_ff));
  sadc_afe_model u_sadc_afe_model (.pclk(pclk), .dac_code(dac_code_ff),
    .sample_switch(sample_switch_ff), .power_on(conv_power_on_ff),
    .channel(channel_select_ff), .chan_levels(LEVELS), .cmp_above(cmp_above));
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready_ff !== 1'h1);
    rdata = prdata_ff;
    rerr = pslverr_ff;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rdata, e)
  endtask
  // Cycles until the switch closes or the flag rises
  task automatic wait_for(input logic sw, output int n);
    n = 0;
    while ((sw ? sample_switch_ff : conv_done_flag_ff) !== 1'h1) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Full conversion with timing, result, status and flag clear
  task automatic convert(input logic [1:0] cs, input logic [2:0] ch, input int h);
    int n;
    wr(A_CTRL, {24'h0, cs, ch, 3'h1});
    repeat (40) @(posedge pclk);
    wr(A_CTRL, {24'h0, cs, ch, 3'h5});
    rd_chk(A_CTRL, {24'h0, cs, ch, 3'h5});
    wait_for(1'h0, n);
    if (h > 0) `CHK(n >= 18 * h - 4 && n <= 20 * h + 4, 1'h1)
    wait_for(1'h1, n);
    if (h > 0) `CHK(n >= 3 * h && n <= 5 * h + 4, 1'h1)
    `CHK(conv_result_reg_ff, LEVELS[ch*8 +: 8])
    rd_chk(A_CTRL, {24'h0, cs, ch, 3'h1});
    rd_chk(A_STAT, 32'h1);
    wr(A_STAT, 32'h1);
    rd_chk(A_STAT, 32'h0);
  endtask
  task automatic report_and_stop;
    if (err_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    int n;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    rd_chk(A_CTRL, 32'h0);
    rd_chk(A_PCFG, 32'h0);
    wr(A_CTRL, 32'h4);
    rd_chk(A_CTRL, 32'h0);
    apb(1'h0, 14'h0100, 32'h0);
    `CHK({rerr, rdata}, 33'h1_0000_0000)
    port_pin_levels <= 8'hA5;
    for (int i = 0; i < 8; i++) begin
      wr(A_PCFG, 32'hF8 | i);
      rd_chk(A_PCFG, i);
      `CHK(analog_mask_ff, MASKS[i/2])
      `CHK(vref_from_pin_ff, i[0] && i < 6)
      rd_chk(A_PORT, {24'h0, 8'hA5 & ~MASKS[i/2]});
    end
    wr(A_PCFG, 32'h0);
    convert(2'h0, 3'h0, 1);
    convert(2'h1, 3'h3, 4);
    convert(2'h2, 3'h5, 16);
    sleep_mode <= 1'h1;
    convert(2'h3, 3'h7, 0);
    wr(A_CTRL, 32'h49);
    repeat (40) @(posedge pclk);
    wr(A_CTRL, 32'h4D);
    repeat (300) @(posedge pclk);
    `CHK(conv_done_flag_ff, 1'h0)
    rd_chk(A_CTRL, 32'h4D);
    sleep_mode <= 1'h0;
    wait_for(1'h0, n);
    `CHK(conv_result_reg_ff, LEVELS[15:8])
    wr(A_STAT, 32'h1);
    wr(A_CTRL, 32'h51);
    repeat (40) @(posedge pclk);
    wr(A_CTRL, 32'h55);
    repeat (20) @(posedge pclk);
    wr(A_CTRL, 32'h51);
    wait_for(1'h1, n);
    `CHK(n >= 12 && n <= 24, 1'h1)
    repeat (200) @(posedge pclk);
    `CHK({conv_done_flag_ff, conv_result_reg_ff}, {1'h0, LEVELS[15:8]})
    report_and_stop;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    err_count++;
    report_and_stop;
  end
endmodule
bind sadc_top sadc_top_monitor #(.NUM_CH(NUM_CH), .WIDTH(WIDTH)) u_sadc_top_monitor (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .sleep_mode(sleep_mode), .dac_code_ff(dac_code_ff),
  .sample_switch_ff(sample_switch_ff), .channel_select_ff(channel_select_ff),
  .vref_from_pin_ff(vref_from_pin_ff), .analog_mask_ff(analog_mask_ff),
  .conv_power_on_ff(conv_power_on_ff), .conv_done_flag_ff(conv_done_flag_ff),
  .conv_result_reg_ff(conv_result_reg_ff));
